/* File: core/edq_top.sv */
/*
  Encoder front end: fractional encoder divider and quadrature decoder with
  line and frame triggers, behind an AXI4-Lite register slave.
  Assumes encoder phases arrive asynchronously on pins and that the bus master
  runs on clk.
*/
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`include "edq_params.svh"

module edq_top #(
  parameter int SLOW_CYCLES = `EDQ_SLOW_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic enc_a_pin,
  input wire logic enc_b_pin,
  output logic line_trigger,
  output logic frame_trigger,
  output logic divider_out,
  output logic camera_trigger,
  output logic line_timing_out,
  output logic timing_table_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State and helpers

  localparam logic [15:0] SLOW_LIM = 16'(SLOW_CYCLES);

  edq_pkg::edq_state_t st_ff;
  edq_pkg::edq_state_t nxt_st;
  logic qreset_req;
  logic [23:0] in_low;
  logic win_now;

  // Merge write data into a word under byte strobes
  function automatic logic [31:0] edq_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Pending write that sets the quadrature reset bit
  assign qreset_req = st_ff.aw_got && st_ff.w_got && st_ff.w_strb[3] &&
                      st_ff.w_data[`EDQ_F_QRESET] &&
                      ((st_ff.aw_addr & `EDQ_WORD_MASK) == `EDQ_REG_QUAD_CTRL);
  assign in_low = st_ff.quad_ctrl[`EDQ_F_LOWER_HI:0];
  // Inclusive window on the current counter
  assign win_now = (st_ff.count >= in_low) && (st_ff.count <= st_ff.upper);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic a_new;
    logic b_new;
    logic a_chg;
    logic b_chg;
    logic up;
    logic rising;
    logic moved;
    logic [23:0] cnt_n;
    logic in_win;
    logic dir_ok;
    logic fresh;
    logic take;
    logic [15:0] step;
    logic enc_sel;
    logic din;
    logic din_rise;
    logic [2:0] expo;
    logic [9:0] den;
    logic slow;
    logic [26:0] target;
    logic [26:0] acc_n;
    logic [7:0] rd_addr;
    logic [31:0] wv;
    a_new = st_ff.a_sync[1];
    b_new = st_ff.b_sync[1];
    a_chg = 1'b0;
    b_chg = 1'b0;
    up = 1'b0;
    rising = 1'b0;
    moved = 1'b0;
    cnt_n = st_ff.count;
    in_win = 1'b0;
    dir_ok = 1'b0;
    fresh = 1'b0;
    take = 1'b0;
    step = st_ff.div_ctrl[`EDQ_F_STEP_HI:`EDQ_F_STEP_LO];
    enc_sel = 1'b0;
    din = 1'b0;
    din_rise = 1'b0;
    expo = st_ff.div_ctrl[`EDQ_F_EXP_HI:`EDQ_F_EXP_LO];
    den = st_ff.div_ctrl[`EDQ_F_DEN_HI:`EDQ_F_DEN_LO];
    slow = 1'b0;
    target = '0;
    acc_n = '0;
    rd_addr = s_axi_araddr & `EDQ_WORD_MASK;
    wv = '0;
    nxt_st = st_ff;
    nxt_st.line_pulse = 1'b0;
    nxt_st.frame_pulse = 1'b0;

    // Two-stage synchronisers, then one stage of history for edges
    nxt_st.a_sync = {st_ff.a_sync[0], enc_a_pin};
    nxt_st.b_sync = {st_ff.b_sync[0], enc_b_pin};
    nxt_st.a_prev = a_new;
    nxt_st.b_prev = b_new;

    // Quadrature decode: one phase changing at a time is a step
    a_chg = a_new ^ st_ff.a_prev;
    b_chg = b_new ^ st_ff.b_prev;
    up = a_new ^ st_ff.b_prev;
    rising = (a_chg && a_new) || (b_chg && b_new);
    moved = (a_chg ^ b_chg) && (st_ff.quad_ctrl[`EDQ_F_DECODE] || rising);
    cnt_n = up ? st_ff.count + 24'h1 : st_ff.count - 24'h1;
    in_win = (cnt_n >= in_low) && (cnt_n <= st_ff.upper);
    unique case (st_ff.quad_ctrl[`EDQ_F_ACQ_HI:`EDQ_F_ACQ_LO])
      `EDQ_DIR_BOTH: dir_ok = 1'b1;
      `EDQ_DIR_POS: dir_ok = up;
      `EDQ_DIR_NEG: dir_ok = !up;
      default: dir_ok = 1'b0;
    endcase
    fresh = (cnt_n > st_ff.hi_mark) || (cnt_n < st_ff.lo_mark);
    // Every gate applies at once
    take = moved && dir_ok &&
           (!st_ff.quad_ctrl[`EDQ_F_WIN_EN] || in_win) &&
           (!st_ff.quad_ctrl[`EDQ_F_NO_REACQ] || fresh);
    if (moved) begin
      nxt_st.count = cnt_n;
      nxt_st.dir = up;
      nxt_st.new_lines = take;
    end
    if (take) begin
      nxt_st.line_pulse = 1'b1;
      // Acquired range grows to cover the new value
      if (cnt_n > st_ff.hi_mark) begin
        nxt_st.hi_mark = cnt_n;
      end
      if (cnt_n < st_ff.lo_mark) begin
        nxt_st.lo_mark = cnt_n;
      end
      // Frame trigger after the programmed number of taken counts
      if (st_ff.quad_ctrl[`EDQ_F_STEP_EN] && (step != 16'h0)) begin
        if (st_ff.step_cnt + 16'h1 >= step) begin
          nxt_st.frame_pulse = 1'b1;
          nxt_st.step_cnt = '0;
        end else begin
          nxt_st.step_cnt = st_ff.step_cnt + 16'h1;
        end
      end
    end

    // Undivided encoder signal and divider input selection
    enc_sel = st_ff.quad_ctrl[`EDQ_F_STEP_EN] ? st_ff.frame_pulse : st_ff.line_pulse;
    din = st_ff.div_ctrl[`EDQ_F_DIV_SRC] ? enc_sel : a_new;
    din_rise = din && !st_ff.din_prev;
    nxt_st.din_prev = din;
    if (expo > `EDQ_EXP_MAX) begin
      expo = `EDQ_EXP_MAX;
    end
    if (den == 10'h0) begin
      den = `EDQ_DEN_MIN;
    end

    // Input period measured in clk cycles, saturating
    if (din_rise) begin
      nxt_st.period = st_ff.per_cnt;
      nxt_st.period_valid = 1'b1;
      nxt_st.per_cnt = 16'h1;
    end else if (st_ff.per_cnt != 16'hffff) begin
      nxt_st.per_cnt = st_ff.per_cnt + 16'h1;
    end
    slow = !st_ff.period_valid || (st_ff.per_cnt >= SLOW_LIM) ||
           (st_ff.period >= SLOW_LIM);

    // Mode selection on input speed
    unique case (st_ff.mode)
      edq_pkg::edq_div_lock: begin
        if (slow) begin
          nxt_st.mode = st_ff.div_cfg[`EDQ_F_STOP_SLOW] ? edq_pkg::edq_div_hold
                                                        : edq_pkg::edq_div_slow;
        end
      end
      edq_pkg::edq_div_slow: begin
        if (!slow) begin
          nxt_st.mode = edq_pkg::edq_div_lock;
        end else if (st_ff.div_cfg[`EDQ_F_STOP_SLOW]) begin
          nxt_st.mode = edq_pkg::edq_div_hold;
        end
      end
      edq_pkg::edq_div_hold: begin
        if (!slow) begin
          nxt_st.mode = edq_pkg::edq_div_lock;
        end else if (!st_ff.div_cfg[`EDQ_F_STOP_SLOW]) begin
          nxt_st.mode = edq_pkg::edq_div_slow;
        end
      end
      default: nxt_st.mode = edq_pkg::edq_div_lock;
    endcase

    // Output generation per mode
    unique case (st_ff.mode)
      edq_pkg::edq_div_lock: begin
        // Oscillator: 2^(N+1) half periods per period*M cycles
        target = {11'h0, st_ff.period} * {17'h0, den};
        acc_n = st_ff.acc + 27'(8'h2 << expo);
        if (acc_n >= target) begin
          acc_n = acc_n - target;
          nxt_st.div_out = !st_ff.div_out;
          if (acc_n >= target) begin
            acc_n = '0;
          end
        end
        nxt_st.acc = acc_n;
        // Realign to the input once every M input periods
        if (din_rise) begin
          if (st_ff.lock_cnt + 10'h1 >= den) begin
            nxt_st.lock_cnt = '0;
            if (!st_ff.div_cfg[`EDQ_F_FREE_RUN]) begin
              nxt_st.acc = '0;
            end
          end else begin
            nxt_st.lock_cnt = st_ff.lock_cnt + 10'h1;
          end
        end
      end
      edq_pkg::edq_div_slow: begin
        // Plain divider: toggle every 2M rising input edges
        if (din_rise) begin
          if (st_ff.slow_cnt + 11'h1 >= {den, 1'b0}) begin
            nxt_st.slow_cnt = '0;
            nxt_st.div_out = !st_ff.div_out;
          end else begin
            nxt_st.slow_cnt = st_ff.slow_cnt + 11'h1;
          end
        end
      end
      edq_pkg::edq_div_hold: begin
        nxt_st.slow_cnt = '0;
      end
      default: nxt_st.acc = '0;
    endcase

    // Consumer routing: divided or undivided encoder signal
    for (int i = 0; i < 3; i++) begin
      nxt_st.consumer[i] = st_ff.div_cfg[`EDQ_F_ROUTE_LO + i] ? st_ff.div_out : enc_sel;
    end

    // Bus: address and data taken independently
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr & `EDQ_WORD_MASK;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // Register write once both halves are held
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `EDQ_RESP_OKAY;
      unique case (st_ff.aw_addr)
        `EDQ_REG_DIV_CTRL: begin
          nxt_st.div_ctrl = edq_merge(st_ff.div_ctrl, st_ff.w_data, st_ff.w_strb);
        end
        `EDQ_REG_QUAD_CTRL: begin
          wv = edq_merge(st_ff.quad_ctrl, st_ff.w_data, st_ff.w_strb);
          nxt_st.quad_ctrl = wv & `EDQ_QUAD_WMASK;
        end
        `EDQ_REG_UPPER: begin
          wv = edq_merge({8'h0, st_ff.upper}, st_ff.w_data, st_ff.w_strb);
          nxt_st.upper = wv[23:0];
        end
        `EDQ_REG_DIV_CFG: begin
          wv = edq_merge({25'h0, st_ff.div_cfg}, st_ff.w_data, st_ff.w_strb);
          nxt_st.div_cfg = wv[6:0];
        end
        `EDQ_REG_COUNT, `EDQ_REG_STATUS: nxt_st.bresp = `EDQ_RESP_OKAY;
        default: nxt_st.bresp = `EDQ_RESP_SLVERR;
      endcase
    end
    // Quadrature reset clears counter, history and triggers
    if (qreset_req) begin
      nxt_st.count = '0;
      nxt_st.hi_mark = '0;
      nxt_st.lo_mark = '0;
      nxt_st.step_cnt = '0;
      nxt_st.new_lines = 1'b0;
      nxt_st.line_pulse = 1'b0;
      nxt_st.frame_pulse = 1'b0;
    end

    // Read answer
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `EDQ_RESP_OKAY;
      nxt_st.rdata = '0;
      unique case (rd_addr)
        `EDQ_REG_DIV_CTRL: nxt_st.rdata = st_ff.div_ctrl;
        `EDQ_REG_QUAD_CTRL: nxt_st.rdata = st_ff.quad_ctrl;
        `EDQ_REG_UPPER: nxt_st.rdata = {8'h0, st_ff.upper};
        `EDQ_REG_DIV_CFG: nxt_st.rdata = {25'h0, st_ff.div_cfg};
        `EDQ_REG_COUNT: nxt_st.rdata = {8'h0, st_ff.count};
        `EDQ_REG_STATUS: begin
          nxt_st.rdata[`EDQ_S_PHASE_A] = a_new;
          nxt_st.rdata[`EDQ_S_PHASE_B] = b_new;
          nxt_st.rdata[`EDQ_S_DIR] = st_ff.dir;
          nxt_st.rdata[`EDQ_S_IN_WIN] = win_now;
          nxt_st.rdata[`EDQ_S_NEW_LINES] = st_ff.new_lines;
          nxt_st.rdata[`EDQ_S_SLOW] = (st_ff.mode != edq_pkg::edq_div_lock);
        end
        default: nxt_st.rresp = `EDQ_RESP_SLVERR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.div_ctrl <= `EDQ_RST_DIV_CTRL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign line_trigger = st_ff.line_pulse;
  assign frame_trigger = st_ff.frame_pulse;
  assign divider_out = st_ff.div_out;
  assign camera_trigger = st_ff.consumer[0];
  assign line_timing_out = st_ff.consumer[1];
  assign timing_table_out = st_ff.consumer[2];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Counter moves by one step only
  count_step_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (st_ff.count != $past(st_ff.count)) && !$past(qreset_req) |->
      (st_ff.count == $past(st_ff.count) + 24'h1) ||
      (st_ff.count == $past(st_ff.count) - 24'h1))
    else $error("position counter jumped");

  // Lines in window mode lie inside the limits
  window_gate_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_ff.line_pulse && $past(st_ff.quad_ctrl[`EDQ_F_WIN_EN]) |->
      (st_ff.count >= $past(in_low)) && (st_ff.count <= $past(st_ff.upper)))
    else $error("line taken outside window");

  // Positive-only lines come from upward steps
  dir_pos_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_ff.line_pulse &&
      ($past(st_ff.quad_ctrl[`EDQ_F_ACQ_HI:`EDQ_F_ACQ_LO]) == `EDQ_DIR_POS) |->
      st_ff.dir && (st_ff.count == $past(st_ff.count) + 24'h1))
    else $error("line taken on wrong direction");

  // Reserved direction code takes no line
  dir_reserved_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    ($past(st_ff.quad_ctrl[`EDQ_F_ACQ_HI:`EDQ_F_ACQ_LO]) == 2'h3) |-> !st_ff.line_pulse)
    else $error("line taken with reserved direction");

  // No-reacquire takes only values beyond the acquired range
  reacq_fresh_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_ff.line_pulse && $past(st_ff.quad_ctrl[`EDQ_F_NO_REACQ]) |->
      (st_ff.count > $past(st_ff.hi_mark)) || (st_ff.count < $past(st_ff.lo_mark)))
    else $error("position acquired twice");

  // Hold mode keeps the output still
  hold_static_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (st_ff.mode == edq_pkg::edq_div_hold) ##1 (st_ff.mode == edq_pkg::edq_div_hold) |->
      $stable(st_ff.div_out))
    else $error("divider output moved in hold");

  // Reset bit clears counter and step count on the next edge
  enc_reset_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    qreset_req |=> (st_ff.count == 24'h0) && (st_ff.step_cnt == 16'h0) &&
      (st_ff.hi_mark == 24'h0) && !st_ff.line_pulse)
    else $error("quadrature reset incomplete");

  // Coarse resolution counts on rising phases only
  coarse_rise_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (st_ff.count != $past(st_ff.count)) && !$past(qreset_req) &&
      !$past(st_ff.quad_ctrl[`EDQ_F_DECODE]) |->
      (st_ff.a_prev && !$past(st_ff.a_prev)) || (st_ff.b_prev && !$past(st_ff.b_prev)))
    else $error("coarse mode counted a falling edge");

  // Frame trigger only with a taken line in step mode
  step_frame_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_ff.frame_pulse |-> st_ff.line_pulse && $past(st_ff.quad_ctrl[`EDQ_F_STEP_EN]))
    else $error("frame trigger without step");

  // Write answer stands until taken
  bus_bhold_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_ff.bvalid && !s_axi_bready |=> st_ff.bvalid && $stable(st_ff.bresp))
    else $error("write response dropped");

  // Scenarios
  win_line_c: cover property (@(posedge clk) disable iff (!rst_b)
    st_ff.line_pulse && st_ff.quad_ctrl[`EDQ_F_WIN_EN]);
  frame_c: cover property (@(posedge clk) disable iff (!rst_b) st_ff.frame_pulse);
  hold_c: cover property (@(posedge clk) disable iff (!rst_b)
    st_ff.mode == edq_pkg::edq_div_hold);
  lock_toggle_c: cover property (@(posedge clk) disable iff (!rst_b)
    (st_ff.mode == edq_pkg::edq_div_lock) && $changed(st_ff.div_out));

endmodule

/* File: pkg/edq_params.svh */
/*
  Constants of the encoder divider and quadrature front end: register offsets,
  field positions, reset values, encodings and timing figures.
  Assumes a 40 MHz logic clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef EDQ_PARAMS_SVH
`define EDQ_PARAMS_SVH

// Register offsets
`define EDQ_REG_DIV_CTRL 8'h00
`define EDQ_REG_QUAD_CTRL 8'h04
`define EDQ_REG_UPPER 8'h08
`define EDQ_REG_DIV_CFG 8'h0c
`define EDQ_REG_COUNT 8'h10
`define EDQ_REG_STATUS 8'h14
`define EDQ_WORD_MASK 8'hfc

// Divider control fields
`define EDQ_F_DIV_SRC 1
`define EDQ_F_EXP_HI 5
`define EDQ_F_EXP_LO 3
`define EDQ_F_DEN_HI 15
`define EDQ_F_DEN_LO 6
`define EDQ_F_STEP_HI 31
`define EDQ_F_STEP_LO 16

// Quadrature control fields
`define EDQ_F_LOWER_HI 23
`define EDQ_F_DECODE 24
`define EDQ_F_ACQ_HI 26
`define EDQ_F_ACQ_LO 25
`define EDQ_F_WIN_EN 27
`define EDQ_F_NO_REACQ 28
`define EDQ_F_STEP_EN 30
`define EDQ_F_QRESET 31
`define EDQ_QUAD_WMASK 32'h5fff_ffff

// Divider configuration fields
`define EDQ_F_FREE_RUN 0
`define EDQ_F_STOP_SLOW 1
`define EDQ_F_MCLK_HI 3
`define EDQ_F_MCLK_LO 2
`define EDQ_F_ROUTE_LO 4

// Status fields
`define EDQ_S_PHASE_A 0
`define EDQ_S_PHASE_B 1
`define EDQ_S_DIR 2
`define EDQ_S_IN_WIN 3
`define EDQ_S_NEW_LINES 4
`define EDQ_S_SLOW 5

// Reset values and encodings
`define EDQ_RST_DIV_CTRL 32'h0000_0040
`define EDQ_EXP_MAX 3'h6
`define EDQ_DEN_MIN 10'h001
`define EDQ_DIR_BOTH 2'h0
`define EDQ_DIR_POS 2'h1
`define EDQ_DIR_NEG 2'h2
`define EDQ_RESP_OKAY 2'h0
`define EDQ_RESP_SLVERR 2'h2

// Timing: slowest trackable input period in logic clock cycles
`define EDQ_CLK_HZ 40000000
`define EDQ_FIN_MIN_HZ 1600
`define EDQ_SLOW_CYC (`EDQ_CLK_HZ / `EDQ_FIN_MIN_HZ)

`endif

/* File: pkg/edq_pkg.sv */
/*
  Types of the encoder divider and quadrature front end: divider mode and the
  packed state record of the top module.
  Assumes the constants header is included by the design file.
*/
package edq_pkg;

  // Divider operating mode, Gray coded along lock, slow, hold
  typedef enum logic [1:0] {
    edq_div_lock = 2'h0,
    edq_div_slow = 2'h1,
    edq_div_hold = 2'h3
  } edq_div_mode_t;

  // Whole state of the block
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] div_ctrl;
    logic [31:0] quad_ctrl;
    logic [23:0] upper;
    logic [6:0] div_cfg;
    logic [1:0] a_sync;
    logic [1:0] b_sync;
    logic a_prev;
    logic b_prev;
    logic [23:0] count;
    logic dir;
    logic [23:0] hi_mark;
    logic [23:0] lo_mark;
    logic new_lines;
    logic line_pulse;
    logic frame_pulse;
    logic [15:0] step_cnt;
    logic din_prev;
    logic [15:0] per_cnt;
    logic [15:0] period;
    logic period_valid;
    logic [26:0] acc;
    logic [9:0] lock_cnt;
    logic [10:0] slow_cnt;
    logic div_out;
    edq_div_mode_t mode;
    logic [2:0] consumer;
  } edq_state_t;

endpackage

/* File: tb/edq_enc_model.sv */
/* Encoder partner: a quadrature phase pair on a moving stage.
   Assumes the bench spaces step requests so each level lasts several clocks. */
module edq_enc_model (
  input wire logic clk,
  input wire logic step,
  input wire logic up,
  output logic enc_a,
  output logic enc_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph_ff = 2'h0;
  // One quarter cycle per step request
  always @(posedge clk) begin
    if (step) begin
      ph_ff <= up ? ph_ff + 2'h1 : ph_ff - 2'h1;
    end
  end
  // Gray order 00,10,11,01: A leads B when moving up
  assign enc_a = (ph_ff == 2'h1) || (ph_ff == 2'h2);
  assign enc_b = ph_ff[1];
endmodule

/* File: tb/edq_top_tb.sv */
/* Self-checking bench for the encoder front end.
   Assumes the encoder partner model and the register bus master below. */
`include "edq_params.svh"
module edq_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [31:0] q; int u1, dn, u2;
                  logic [23:0] cnt; int nl, nf; logic dir;} edq_row_t;
  logic clk, rst_b, awv, wv, bry, arv, rry, stp, up, awr, wr_r, bv, arr, rv;
  logic ea, eb, ln, fr, dv, hv, ct, lt, tt, dv_q;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd_d, rdat;
  logic [1:0] rd_r, wb_r, br, rr;
  int miscompares, n_compared, n_ln, n_fr, n_ct, n_dv;
  edq_row_t rows [9] = '{
    '{32'h0100_0000, 8, 0, 0, 24'h000008, 8, 0, 1'b1},
    '{32'h0000_0000, 8, 0, 0, 24'h000004, 4, 0, 1'b1},
    '{32'h0300_0000, 0, 8, 0, 24'hfffff8, 0, 0, 1'b0},
    '{32'h0500_0000, 4, 8, 0, 24'hfffffc, 8, 0, 1'b0},
    '{32'h1100_0000, 4, 2, 4, 24'h000006, 6, 0, 1'b1},
    '{32'h0900_0002, 8, 0, 0, 24'h000008, 4, 0, 1'b1},
    '{32'h1b00_0002, 6, 3, 3, 24'h000006, 4, 0, 1'b1},
    '{32'h4100_0000, 8, 0, 0, 24'h000008, 8, 2, 1'b1},
    '{32'h0700_0000, 4, 0, 0, 24'h000004, 0, 0, 1'b1}};

  edq_top #(.SLOW_CYCLES(200)) u_edq_top (.clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .enc_a_pin(ea),
    .enc_b_pin(eb), .line_trigger(ln), .frame_trigger(fr), .divider_out(dv),
    .camera_trigger(ct), .line_timing_out(lt), .timing_table_out(tt));
  edq_enc_model u_edq_enc_model (.clk(clk), .step(stp), .up(up), .enc_a(ea), .enc_b(eb));

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Clock and trigger pulse counters
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ln === 1'b1) n_ln++;
    if (fr === 1'b1) n_fr++;
    if ({ct, lt, tt} === 3'b111) n_ct++;
    if (dv !== dv_q) n_dv++;
    dv_q = dv;
  end
  // Word compare and count compare
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task chkn(input int got, input int exp);
    chk32(got, exp);
  endtask
  // Bus write: address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
    end while (bv !== 1'b1);
    wb_r = br;
    bry <= 1'b0;
  endtask
  // Bus read: result lands in rd_d and rd_r
  task rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rd_d = rdat;
    rd_r = rr;
    rry <= 1'b0;
  endtask
  // Stage moves n quarter cycles, each level held seven clocks
  task mv(input int n, input logic u);
    repeat (n) begin
      @(posedge clk);
      up <= u;
      stp <= 1'b1;
      @(posedge clk);
      stp <= 1'b0;
      repeat (5) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  // Slow stage: one quarter cycle about every 73 clocks
  task slow(input int n);
    repeat (n) begin
      mv(1, 1'b1);
      repeat (60) @(posedge clk);
    end
  endtask
  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
  // Main sequence: reset, table of moves, locked divider, then divider hold and slow tracking on a slow encoder
  initial begin
    {awv, wv, bry, arv, rry, stp, up, rst_b} = '0;
    {awa, ara, wd} = '0;
    {miscompares, n_compared, n_ln, n_fr, n_ct, n_dv} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(`EDQ_REG_DIV_CTRL);
    chk32(rd_d, `EDQ_RST_DIV_CTRL);
    rd(`EDQ_REG_COUNT);
    chk32(rd_d, 32'h0);
    rd(8'h20);
    chk32({30'h0, rd_r}, {30'h0, `EDQ_RESP_SLVERR});
    wr(8'h20, 32'h0);
    chk32({30'h0, wb_r}, {30'h0, `EDQ_RESP_SLVERR});
    $display("reset test done");
    wr(`EDQ_REG_UPPER, 32'h5);
    wr(`EDQ_REG_DIV_CTRL, 32'h0003_0040);
    foreach (rows[i]) begin
      wr(`EDQ_REG_QUAD_CTRL, rows[i].q | 32'h8000_0000);
      n_ln = 0;
      n_fr = 0;
      n_ct = 0;
      mv(rows[i].u1, 1'b1);
      mv(rows[i].dn, 1'b0);
      mv(rows[i].u2, 1'b1);
      rd(`EDQ_REG_QUAD_CTRL);
      chk32(rd_d, rows[i].q);
      rd(`EDQ_REG_COUNT);
      chk32(rd_d, {8'h0, rows[i].cnt});
      rd(`EDQ_REG_STATUS);
      chk32({31'h0, rd_d[`EDQ_S_DIR]}, {31'h0, rows[i].dir});
      chkn(n_ln, rows[i].nl);
      chkn(n_fr, rows[i].nf);
      chkn(n_ct, rows[i].q[`EDQ_F_STEP_EN] ? rows[i].nf : rows[i].nl);
      $display("row %0d done", i);
    end
    // Locked divider at 2^2/1 on a 28-clock phase A period: about 8 toggles per period
    repeat (300) @(posedge clk);
    wr(`EDQ_REG_DIV_CTRL, 32'h0003_0050);
    n_dv = 0;
    mv(32, 1'b1);
    chkn(n_dv >= 50 && n_dv <= 64, 1);
    $display("lock test done");
    wr(`EDQ_REG_DIV_CFG, 32'h2);
    repeat (400) @(posedge clk);
    hv = dv;
    rd(`EDQ_REG_STATUS);
    chk32({31'h0, rd_d[`EDQ_S_SLOW]}, 32'h1);
    n_dv = 0;
    slow(16);
    chkn(n_dv, 0);
    chk32({31'h0, dv}, {31'h0, hv});
    // Slow tracking, all consumers on the divider: 4 rises of A give 2 toggles
    wr(`EDQ_REG_DIV_CFG, 32'h70);
    n_dv = 0;
    slow(16);
    chkn(n_dv, 2);
    chk32({29'h0, ct, lt, tt}, {29'h0, {3{dv}}});
    $display("hold test done");
    wrap_up;
  end
endmodule
